// ---- rtl/sar_conversion_sequencer.sv ----
// Successive-approximation conversion sequencer with its result FIFO.
`timescale 1ns/1ps

// ------------------------------------------------------------
// Result FIFO
// ------------------------------------------------------------
module sar_result_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // Storage words, written at the write pointer.
  logic [WIDTH-1:0] mem [DEPTH];
  // Pointers and fill level of the storage.
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Full storage refuses words; the source must stall.
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  // The output register takes a word when empty or drained.
  assign pop = (count != '0) && (!out_valid || out_ready);

  // Write side of the storage array.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointer and fill level bookkeeping.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // Registered output stage so the port comes from a flip-flop.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : sar_result_fifo

// ------------------------------------------------------------
// Conversion sequencer
// ------------------------------------------------------------
module sar_conversion_sequencer
  import sar_seq_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic convert_start,
  input wire logic fast_mode,
  input wire logic comparator_high,
  output logic hold,
  output logic pos_array_ground_switch,
  output logic neg_array_ground_switch,
  output logic input_connect,
  output logic reference_ground,
  output logic [15:0] dac_bits,
  output logic power_on,
  output logic busy,
  output logic result_valid,
  input wire logic result_ready,
  output logic [15:0] result_code,
  output logic result_first_fast
);

  // Present state of the sequence.
  seq_state_t state;
  // Previous convert_start level, for edge detection.
  logic start_prev;
  // Cycles since the last accepted start, saturating.
  logic [7:0] period_cnt;
  // Wait counter for aperture and bit settling.
  logic [3:0] wait_cnt;
  // Bit under trial.
  logic [3:0] bit_idx;
  // Previous fast_mode level.
  logic fast_prev;
  // A fast-mode warm-up conversion is still owed.
  logic warm_pending;
  // Tag carried by the conversion now in flight.
  logic warm_tag;
  // Buffer handshake toward the result FIFO.
  logic fifo_in_ready;
  logic push;
  logic start_edge;
  logic rate_ok;
  logic start_take;
  logic [15:0] fifo_code;
  logic fifo_tag;

  // Least spacing of starts for the chosen mode.
  function automatic logic [7:0] min_period(input logic fast);
    min_period = fast ? FAST_PERIOD_CYCLES : NORMAL_PERIOD_CYCLES;
  endfunction : min_period

  // The internal clock and convert_start pace the sequence; fast_mode sets the start spacing and a full buffer stalls it.
  assign start_edge = convert_start && !start_prev;
  assign rate_ok = (period_cnt >= min_period(fast_mode) - 8'h01);
  assign start_take = start_edge && rate_ok && (state == ST_ACQUIRE);
  assign push = (state == ST_PUBLISH) && fifo_in_ready;

  // ------------------------------------------------------------
  // Start detection and rate limiting
  // ------------------------------------------------------------

  // Tracks the start level and the time since the last start.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_prev <= 1'b0;
      period_cnt <= 8'hFF;
    end else begin
      start_prev <= convert_start;
      if (start_take) begin
        period_cnt <= 8'h00;
      end else if (period_cnt != 8'hFF) begin
        period_cnt <= period_cnt + 8'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Sequence state machine
  // ------------------------------------------------------------

  // Steps from acquisition through bit trials to publication.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_ACQUIRE;
      wait_cnt <= 4'h0;
      bit_idx <= 4'h0;
    end else begin
      case (state)
        ST_ACQUIRE: begin
          if (start_take) begin
            state <= ST_APERTURE;
            wait_cnt <= 4'h0;
          end
        end
        ST_APERTURE: begin
          // Fixed delay from the edge to the hold instant.
          if (wait_cnt == APERTURE_CYCLES - 4'h1) begin
            state <= ST_OPEN_GROUND;
          end else begin
            wait_cnt <= wait_cnt + 4'h1;
          end
        end
        ST_OPEN_GROUND: begin
          // Ground switches open one cycle before isolation.
          state <= ST_ISOLATE;
        end
        ST_ISOLATE: begin
          state <= ST_DECIDE;
          bit_idx <= 4'(MSB_INDEX);
          wait_cnt <= 4'h0;
        end
        ST_DECIDE: begin
          // Each trial settles before the comparator is read.
          if (wait_cnt == SETTLE_CYCLES - 4'h1) begin
            wait_cnt <= 4'h0;
            if (bit_idx == 4'h0) begin
              state <= ST_PUBLISH;
            end else begin
              bit_idx <= bit_idx - 4'h1;
            end
          end else begin
            wait_cnt <= wait_cnt + 4'h1;
          end
        end
        ST_PUBLISH: begin
          // A full buffer stalls here until room appears.
          if (fifo_in_ready) begin
            state <= ST_ACQUIRE;
          end
        end
        default: begin
          state <= ST_ACQUIRE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Capacitor array trial bits
  // ------------------------------------------------------------

  // Sets each trial bit and keeps it only if the comparator says so.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dac_bits <= CODE_ZERO;
    end else if (state == ST_ISOLATE) begin
      // Largest element first: half of the reference span.
      dac_bits <= CODE_MSB;
    end else if (state == ST_DECIDE && wait_cnt == SETTLE_CYCLES - 4'h1) begin
      // The register cannot wrap, so over and underrange saturate.
      dac_bits[bit_idx] <= comparator_high;
      if (bit_idx != 4'h0) begin
        dac_bits[bit_idx - 4'h1] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Analog switch controls
  // ------------------------------------------------------------

  // Ground switches close through acquisition and the aperture delay; inputs stay connected one cycle longer.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hold <= 1'b0;
      pos_array_ground_switch <= 1'b1;
      neg_array_ground_switch <= 1'b1;
      input_connect <= 1'b1;
      reference_ground <= 1'b0;
    end else begin
      // Hold rises as the aperture delay expires.
      hold <= (state == ST_APERTURE && wait_cnt == APERTURE_CYCLES - 4'h1)
        || state == ST_OPEN_GROUND || state == ST_ISOLATE
        || state == ST_DECIDE;
      // The push into the buffer restores acquisition as busy falls, so idle is never half set.
      pos_array_ground_switch <= (state == ST_ACQUIRE) || (state == ST_APERTURE)
        || push;
      neg_array_ground_switch <= (state == ST_ACQUIRE) || (state == ST_APERTURE)
        || push;
      input_connect <= (state == ST_ACQUIRE) || (state == ST_APERTURE)
        || (state == ST_OPEN_GROUND) || push;
      reference_ground <= (state == ST_ISOLATE) || (state == ST_DECIDE);
    end
  end

  // ------------------------------------------------------------
  // Power and busy indication
  // ------------------------------------------------------------

  // Fast mode stays powered; normal mode powers only while converting.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      power_on <= 1'b0;
      busy <= 1'b0;
    end else begin
      power_on <= fast_mode || start_take
        || (state != ST_ACQUIRE && !push);
      busy <= start_take || (state != ST_ACQUIRE && !push);
    end
  end

  // ------------------------------------------------------------
  // Fast-mode warm-up tagging
  // ------------------------------------------------------------

  // Marks the first conversion after fast mode begins.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fast_prev <= 1'b0;
      warm_pending <= 1'b0;
      warm_tag <= 1'b0;
    end else begin
      fast_prev <= fast_mode;
      if (start_take) begin
        // Normal-mode conversions are never tagged.
        warm_tag <= fast_mode && (warm_pending || !fast_prev);
      end
      // A start in the cycle fast mode begins takes the tag itself, so nothing stays pending.
      if (fast_mode && !fast_prev) begin
        warm_pending <= !start_take;
      end else if (start_take || !fast_mode) begin
        warm_pending <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Result buffer
  // ------------------------------------------------------------

  // Each pushed word is the code of the conversion just finished.
  sar_result_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(state == ST_PUBLISH),
    .in_ready(fifo_in_ready),
    .in_data({warm_tag, dac_bits}),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data({fifo_tag, fifo_code})
  );

  assign result_code = fifo_code;
  assign result_first_fast = fifo_tag;

endmodule : sar_conversion_sequencer

// ---- rtl/sar_seq_pkg.sv ----
// Constants shared by the conversion sequencer and its result buffer.
package sar_seq_pkg;

  // ------------------------------------------------------------
  // Resolution and output codes
  // ------------------------------------------------------------
  localparam int RESULT_BITS = 16;
  localparam int MSB_INDEX = RESULT_BITS - 1;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MSB = 16'h8000;

  // ------------------------------------------------------------
  // Timing at the core clock
  // ------------------------------------------------------------
  localparam int CLOCK_MHZ = 200;
  localparam int FAST_PERIOD_NS = 400;
  localparam int NORMAL_PERIOD_NS = 500;
  localparam int APERTURE_NS = 10;
  localparam int SETTLE_NS = 10;
  localparam logic [7:0] FAST_PERIOD_CYCLES =
    8'((FAST_PERIOD_NS * CLOCK_MHZ + 999) / 1000);
  localparam logic [7:0] NORMAL_PERIOD_CYCLES =
    8'((NORMAL_PERIOD_NS * CLOCK_MHZ + 999) / 1000);
  localparam logic [3:0] APERTURE_CYCLES =
    4'((APERTURE_NS * CLOCK_MHZ + 999) / 1000);
  localparam logic [3:0] SETTLE_CYCLES =
    4'((SETTLE_NS * CLOCK_MHZ + 999) / 1000);

  // ------------------------------------------------------------
  // Result buffer shape
  // ------------------------------------------------------------
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = RESULT_BITS + 1;

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ACQUIRE,
    ST_APERTURE,
    ST_OPEN_GROUND,
    ST_ISOLATE,
    ST_DECIDE,
    ST_PUBLISH
  } seq_state_t;

endpackage : sar_seq_pkg

// ---- test/sar_host_model.sv ----
// Far-side model: analog input, comparator and result reader.
`timescale 1ns/1ps
module sar_host_model (
  input wire logic clock,
  input wire logic hold,
  input wire logic [15:0] dac_bits,
  input wire logic signed [31:0] level,
  input wire logic stall,
  output logic comparator_high,
  output logic result_ready
);
  // Input level frozen while the sample is held.
  logic signed [31:0] held = 0;
  // Previous hold, used to find the moment the sample is taken.
  logic hold_d = 1'b0;

  // Freeze the input when hold rises, so later changes cannot leak in.
  always @(posedge clock) begin
    hold_d <= hold;
    if (hold && !hold_d) begin
      held <= level;
    end
  end

  // The comparator keeps a bit when the held level reaches the trial code.
  assign comparator_high = (held >= $signed({16'h0000, dac_bits}));
  // The reader takes every word unless the bench stalls it.
  assign result_ready = !stall;
endmodule : sar_host_model

// ---- test/sar_seq_sva.sv ----
// Port-level assertion checker for the conversion sequencer.
`timescale 1ns/1ps
module sar_seq_checker
  import sar_seq_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic convert_start,
  input wire logic fast_mode,
  input wire logic comparator_high,
  input wire logic hold,
  input wire logic pos_array_ground_switch,
  input wire logic neg_array_ground_switch,
  input wire logic input_connect,
  input wire logic reference_ground,
  input wire logic [15:0] dac_bits,
  input wire logic power_on,
  input wire logic busy,
  input wire logic result_valid,
  input wire logic result_ready,
  input wire logic [15:0] result_code,
  input wire logic result_first_fast
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_start_busy: assert property ($rose(busy) |->
    $past(convert_start) && !$past(convert_start, 2))
    else $error("busy rose without a start edge");
  a_aperture_hold: assert property ($rose(busy) |-> ##2 $rose(hold))
    else $error("hold did not follow the aperture");
  a_open_first: assert property ($fell(pos_array_ground_switch) |->
    hold && input_connect ##1 $fell(input_connect) && reference_ground)
    else $error("arrays isolated before ground switches opened");
  a_switch_pair: assert property (pos_array_ground_switch == neg_array_ground_switch)
    else $error("ground switches disagree");
  a_msb_trial: assert property ($rose(reference_ground) |-> dac_bits == CODE_MSB)
    else $error("first trial is not the top bit");
  a_hold_window: assert property ($rose(hold) |-> ##[30:40] $fell(hold))
    else $error("bit decisions took the wrong time");
  a_busy_power: assert property (busy |-> power_on)
    else $error("converting while powered down");
  a_normal_off: assert property (!fast_mode && !$past(fast_mode) && !busy
    && !$past(busy) |-> !power_on)
    else $error("normal mode stayed powered between conversions");
  a_fast_stay: assert property (fast_mode && $past(fast_mode) && $past(power_on) |-> power_on)
    else $error("fast mode powered down");
  a_idle_acquire: assert property (!busy |-> !hold && pos_array_ground_switch
    && input_connect && !reference_ground)
    else $error("idle without acquisition set up");
  a_done_publish: assert property ($fell(busy) |-> ##[0:1] result_valid)
    else $error("no result after conversion");

  // Main scenarios reached.
  c_conv: cover property ($rose(busy));
  c_fast_tag: cover property (result_valid && result_first_fast);
  c_stalled: cover property (busy && !hold && result_valid && !result_ready);
endmodule : sar_seq_checker

bind sar_conversion_sequencer sar_seq_checker chk (.clock, .reset_n, .convert_start, .fast_mode,
  .comparator_high, .hold, .pos_array_ground_switch, .neg_array_ground_switch, .input_connect,
  .reference_ground, .dac_bits, .power_on, .busy, .result_valid, .result_ready, .result_code,
  .result_first_fast);

// ---- test/tb.sv ----
// Self-checking testbench for the conversion sequencer.
`timescale 1ns/1ps
module tb;
  import sar_seq_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clock, reset_n, convert_start, fast_mode, stall, comparator_high, hold;
  logic pos_array_ground_switch, neg_array_ground_switch, input_connect, reference_ground;
  logic power_on, busy, result_valid, result_ready, result_first_fast;
  logic [15:0] dac_bits, result_code;
  logic signed [31:0] level;
  logic [16:0] got_q[$]; // Words taken by the reader, tag on top.
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;

  // The clock runs at 200 MHz.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  sar_conversion_sequencer DUT (.clock, .reset_n, .convert_start, .fast_mode, .comparator_high,
    .hold, .pos_array_ground_switch, .neg_array_ground_switch, .input_connect, .reference_ground,
    .dac_bits, .power_on, .busy, .result_valid, .result_ready, .result_code, .result_first_fast);
  sar_host_model host (.clock, .hold, .dac_bits, .level, .stall, .comparator_high, .result_ready);

  // Record every word handed over, and cut a hang short.
  always @(posedge clock) begin
    cycles++;
    if (result_valid === 1'b1 && result_ready === 1'b1) begin
      got_q.push_back({result_first_fast, result_code});
    end
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One start pulse, then a wait of gap cycles.
  task automatic convert(input int lvl, input int gap);
    @(negedge clock);
    level = lvl;
    convert_start = 1'b1;
    @(negedge clock);
    convert_start = 1'b0;
    repeat (gap) @(negedge clock);
  endtask : convert

  // Compare the oldest word with the saturated ideal code.
  task automatic take(input string what, input logic tag, input int lvl);
    logic [15:0] exp;
    logic [16:0] w;
    exp = (lvl > 65535) ? 16'hFFFF : (lvl < 0) ? 16'h0000 : 16'(lvl);
    w = (got_q.size() != 0) ? got_q.pop_front() : 17'h1FFFF;
    check(what, w, {tag, exp});
  endtask : take

  task automatic close_out();
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Normal mode codes at the boundaries, beyond both ends too.
  task automatic s_codes();
    int lv[8] = '{0, 1, 32767, 32768, 32769, 65535, 70000, -3};
    foreach (lv[i]) begin
      convert(lv[i], 100);
      check("power", {16'h0000, power_on}, 17'h00000);
      take("code", 1'b0, lv[i]);
    end
  endtask : s_codes

  // Fast mode: first word tagged for discard, then valid ones.
  task automatic s_fast();
    logic [16:0] w;
    fast_mode = 1'b1;
    convert(12345, 80);
    convert(54321, 80);
    check("power", {16'h0000, power_on}, 17'h00001);
    check("count", 17'(got_q.size()), 17'h00002);
    w = got_q.pop_front();
    check("tag", {16'h0000, w[16]}, 17'h00001);
    take("fast", 1'b0, 54321);
    fast_mode = 1'b0;
    // The normal-mode spacing counts from the last fast start, so let it run out.
    repeat (20) @(negedge clock);
  endtask : s_fast

  // Starts while busy or too soon are ignored.
  task automatic s_refuse();
    convert(1000, 5);
    check("busy", {16'h0000, busy}, 17'h00001);
    convert(2000, 45);
    convert(3000, 100);
    check("count", 17'(got_q.size()), 17'h00001);
    take("code", 1'b0, 1000);
  endtask : s_refuse

  // Fill the buffer with the reader stalled, then drain in order.
  // The buffer holds 32 words plus its output stage, so the 34th result must stall.
  task automatic s_full();
    stall = 1'b1;
    for (int i = 0; i < 34; i++) begin
      convert(i * 1000, 100);
    end
    check("busy", {16'h0000, busy}, 17'h00001);
    stall = 1'b0;
    repeat (100) @(negedge clock);
    check("count", 17'(got_q.size()), 17'h00022);
    for (int i = 0; i < 34; i++) begin
      take("order", 1'b0, i * 1000);
    end
  endtask : s_full

  // Main sequence: reset for two cycles, idle check, then scenarios.
  initial begin
    reset_n = 1'b0;
    convert_start = 1'b0;
    fast_mode = 1'b0;
    stall = 1'b0;
    level = 0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    check("idle", {12'h000, busy, hold, power_on, pos_array_ground_switch, input_connect},
      17'h00003);
    s_codes();
    s_fast();
    s_refuse();
    s_full();
    close_out();
  end
endmodule : tb
